//--- inc/tdm_chain_pkg.sv
// Purpose: Shared constants for the chained TDM microphone link
// Assumes: One system clock; link clock sampled as ordinary input
// Notes:   Slot width is a plain choice, not a documented figure
package tdm_chain_pkg;
    localparam int unsigned MAX_SLOTS      = 16;
    localparam int unsigned SLOT_IDX_W     = 4;
    localparam int unsigned WORD_W         = 24;
    localparam int unsigned SLOT_BITS      = 32;
    localparam int unsigned BIT_CNT_W      = 5;
    localparam int unsigned FRAME_BITS     = MAX_SLOTS * SLOT_BITS;
    localparam int unsigned FRAME_CNT_W    = 9;
    localparam int unsigned SYS_CLK_HZ     = 40000000;
    localparam int unsigned LINK_CLK_HZ    = 5000000;
    localparam int unsigned HALF_DIV       = SYS_CLK_HZ / (2 * LINK_CLK_HZ);
    localparam int unsigned DIV_W          = 3;
    localparam int unsigned IDLE_EDGES     = 64;
    localparam int unsigned IDLE_CNT_W     = 7;
    localparam logic [SLOT_IDX_W-1:0] SLOT_RST = 4'h0;
endpackage

//--- inc/tdm_chain_if.sv
// Purpose: Link wires between clock master and one microphone
// Assumes: Data line is shared; testbench resolves enables
// Notes:   One instance per microphone hop
`timescale 1ns/1ps
`default_nettype none
interface tdm_chain_if;
    logic bit_clk;
    logic word_sel;
    logic chain_trigger_out;
    logic sd_out;
    logic sd_oe;
    logic sd_in;
    modport mic (
        input  bit_clk,
        input  word_sel,
        output chain_trigger_out,
        output sd_out,
        output sd_oe,
        input  sd_in
    );
    modport master (
        output bit_clk,
        output word_sel,
        input  sd_in
    );
endinterface
`default_nettype wire

//--- src/tdm_mic_end.sv
// Purpose: Microphone end: enumeration, buffered word, slot output
// Assumes: Link clock and select arrive async; sampled twice
// Notes:   Data changes on falling bit clock, master samples next fall
`timescale 1ns/1ps
`default_nettype none

module tdm_mic_end
    import tdm_chain_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    tdm_chain_if.mic               link,
    input  wire logic [WORD_W-1:0] sample_word,
    output var  logic [SLOT_IDX_W-1:0] slot_index,
    output var  logic              synced,
    output var  logic              sample_strobe
);
    typedef enum logic [1:0] {ST_RESET, ST_ENUM, ST_RUN} state_t;

    state_t                 state;
    logic [1:0]             clk_sync;
    logic [1:0]             ws_sync;
    logic                   clk_prev;
    logic                   ws_prev;
    logic [IDLE_CNT_W-1:0]  idle_cnt;
    logic [FRAME_CNT_W-1:0] frame_pos;
    logic [BIT_CNT_W-1:0]   bit_pos;
    logic [WORD_W-1:0]      buffer;
    logic [WORD_W-1:0]      shifter;
    logic                   sending;
    logic                   trig;
    logic                   sd;
    logic                   oe;

    wire rise       = clk_sync[1] & ~clk_prev;
    wire fall       = ~clk_sync[1] & clk_prev;
    wire ws_edge    = rise & ws_sync[1] & ~ws_prev;
    wire clk_lost   = (idle_cnt == IDLE_CNT_W'(IDLE_EDGES)) & ~(rise | fall);
    wire [SLOT_IDX_W-1:0] pos_slot = frame_pos[FRAME_CNT_W-1 -: SLOT_IDX_W];
    wire slot_done  = sending & fall & (bit_pos == BIT_CNT_W'(SLOT_BITS-1));
    wire frame_wrap = rise & (frame_pos == FRAME_CNT_W'(FRAME_BITS-1));

    assign link.chain_trigger_out = trig;
    assign link.sd_out            = sd;
    assign link.sd_oe             = oe;

    // Two flops before any use of link inputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_sync <= 2'h0;
            ws_sync  <= 2'h0;
            clk_prev <= 1'b0;
            ws_prev  <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], link.bit_clk};
            ws_sync  <= {ws_sync[0], link.word_sel};
            clk_prev <= clk_sync[1];
            if (rise) ws_prev <= ws_sync[1];
        end
    end

    // Watchdog on link clock activity
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) idle_cnt <= '0;
        else if (rise | fall) idle_cnt <= '0;
        else if (!clk_lost) idle_cnt <= idle_cnt + 1'b1;
    end

    // Frame position counter from the shared bit clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) frame_pos <= '0;
        else if (rise)
            frame_pos <= frame_pos + 1'b1;
        else if (state == ST_RESET) frame_pos <= '0;
    end

    // Sequencing: reset, enumerate, run
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= ST_RESET;
            slot_index <= SLOT_RST;
            synced     <= 1'b0;
        end else if (clk_lost) begin
            state  <= ST_RESET;
            synced <= 1'b0;
        end else begin
            unique case (state)
                ST_RESET: if (rise) state <= ST_ENUM;
                ST_ENUM: if (ws_edge) begin
                    // Own select arrives at the count of slots ahead
                    slot_index <= pos_slot;
                    state      <= ST_RUN;
                    synced     <= 1'b1;
                end
                ST_RUN: ;
            endcase
        end
    end

    // Frame start shared by all mics: word captured at one instant
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            buffer        <= '0;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= frame_wrap & (state == ST_RUN);
            if (frame_wrap && state == ST_RUN)
                buffer <= sample_word;
        end
    end

    // Slot output and trigger forwarding
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sending <= 1'b0;
            bit_pos <= '0;
            shifter <= '0;
            trig    <= 1'b0;
            sd      <= 1'b0;
            oe      <= 1'b0;
        end else if (state != ST_RUN && state != ST_ENUM) begin
            sending <= 1'b0;
            trig    <= 1'b0;
            oe      <= 1'b0;
            sd      <= 1'b0;
        end else begin
            if (ws_edge && !sending) begin
                sending <= 1'b1;
                bit_pos <= '0;
                shifter <= buffer;
            end else if (sending && fall) begin
                oe      <= (state == ST_RUN);
                sd      <= shifter[WORD_W-1];
                shifter <= {shifter[WORD_W-2:0], 1'b0};
                bit_pos <= bit_pos + 1'b1;
            end
            if (slot_done) begin
                sending <= 1'b0;
                oe      <= 1'b0;
                sd      <= 1'b0;
                trig    <= 1'b1;
            end else if (trig && fall) begin
                trig <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- src/tdm_master_end.sv
// Purpose: Clock master end: bit clock, frame select, slot capture
// Assumes: Bit clock made here by divider from clk
// Notes:   Select pulses one bit period at each frame start except the first after run
`timescale 1ns/1ps
`default_nettype none
module tdm_master_end
    import tdm_chain_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    tdm_chain_if.master            link,
    input  wire logic              run,
    output var  logic [WORD_W-1:0] rx_word,
    output var  logic [SLOT_IDX_W-1:0] rx_slot,
    output var  logic              rx_valid
);
    logic [DIV_W-1:0]       div;
    logic                   bclk;
    logic                   ws;
    logic [FRAME_CNT_W-1:0] pos;
    logic [1:0]             sd_sync;
    logic [WORD_W-1:0]      shifter;

    wire tick  = (div == DIV_W'(HALF_DIV-1));
    wire bit_end = tick & bclk;
    wire [BIT_CNT_W-1:0] bit_in = pos[BIT_CNT_W-1:0];
    wire [SLOT_IDX_W-1:0] slot_in = pos[FRAME_CNT_W-1 -: SLOT_IDX_W];

    assign link.bit_clk  = bclk;
    assign link.word_sel = ws;

    // Shared bit clock; stopping it sends the array to standby
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div  <= '0;
            bclk <= 1'b0;
        end else if (!run) begin
            div  <= '0;
            bclk <= 1'b0;
        end else begin
            div <= tick ? '0 : div + 1'b1;
            if (tick) bclk <= ~bclk;
        end
    end

    // Frame select to first mic only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos <= '0;
            ws  <= 1'b0;
        end else if (!run) begin
            pos <= '0;
            ws  <= 1'b0;
        end else if (tick && bclk) begin
            pos <= pos + 1'b1;
            ws  <= (pos == FRAME_CNT_W'(FRAME_BITS-1));
        end
    end

    // Capture data line late in bits 1 to 24 of each slot, past the synchroniser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sd_sync  <= 2'h0;
            shifter  <= '0;
            rx_word  <= '0;
            rx_slot  <= SLOT_RST;
            rx_valid <= 1'b0;
        end else begin
            sd_sync  <= {sd_sync[0], link.sd_in};
            rx_valid <= 1'b0;
            if (bit_end && bit_in > BIT_CNT_W'(0)
                && bit_in <= BIT_CNT_W'(WORD_W)) begin
                shifter <= {shifter[WORD_W-2:0], sd_sync[1]};
            end
            if (bit_end && bit_in == BIT_CNT_W'(WORD_W+1)) begin
                rx_word  <= shifter;
                rx_slot  <= slot_in;
                rx_valid <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/tdm_mic_chain_sync_checker.sv
// Purpose: Link checks on the master to first microphone hop
// Assumes: One bit period is eight clk cycles
// Notes:   Counters track drive span and link clock idle time
`timescale 1ns/1ps
`default_nettype none
module tdm_mic_chain_sync_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bit_clk,
    input wire logic word_sel,
    input wire logic chain_trigger_out,
    input wire logic sd_out,
    input wire logic sd_oe,
    input wire logic sd_in
);
    logic [7:0] oe_cnt;
    logic [7:0] idle_cnt;
    logic       bit_q;
    wire  logic bit_moved = bit_clk != bit_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_cnt   <= 8'h00;
            idle_cnt <= 8'h00;
            bit_q    <= 1'b0;
        end else begin
            oe_cnt   <= sd_oe ? oe_cnt + 8'h01 : 8'h00;
            idle_cnt <= bit_moved ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hFF};
            bit_q    <= bit_clk;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_sel_one_bit: assert property ($rose(word_sel) |-> word_sel[*8] ##1 !word_sel)
        else $error("word select not one bit long");
    a_trig_short: assert property ($rose(chain_trigger_out) |-> ##[1:16] !chain_trigger_out)
        else $error("trigger pulse too long");
    a_trig_slot_end: assert property ($rose(chain_trigger_out) |-> $past(word_sel, 256))
        else $error("trigger not at end of slot zero");
    a_oe_no_trig: assert property (sd_oe |-> !chain_trigger_out)
        else $error("trigger while driving data");
    a_oe_after_sel: assert property ($rose(sd_oe) |-> $past(word_sel, 8))
        else $error("drive not started by select");
    a_oe_span: assert property ($fell(sd_oe) |-> oe_cnt >= 8'hF4 && oe_cnt <= 8'hFC)
        else $error("drive span not 31 bits");
    a_bit_hold: assert property (sd_oe && $changed(sd_out) |=> $stable(sd_out)[*6])
        else $error("data bit changed within bit");
    a_idle_quiet: assert property (idle_cnt > 8'h46 |-> !sd_oe && !chain_trigger_out)
        else $error("activity with stopped clock");
endmodule
`default_nettype wire

//--- testbench/tdm_mic_chain_sync_tb.sv
// Purpose: Master and two chained microphones on one data line
// Assumes: Inputs change at falling clk edge
// Notes:   Data line pulled low when nobody drives
`timescale 1ns/1ps
`default_nettype none
module tdm_mic_chain_sync_tb import tdm_chain_pkg::*; ;
    logic                  clk;
    logic                  sys_rst;
    logic                  run;
    logic [WORD_W-1:0]     word0;
    logic [WORD_W-1:0]     word1;
    logic [WORD_W-1:0]     rx_word;
    logic [SLOT_IDX_W-1:0] slot0;
    logic [SLOT_IDX_W-1:0] slot1;
    logic [SLOT_IDX_W-1:0] rx_slot;
    logic                  synced0;
    logic                  synced1;
    logic                  rx_valid;
    int                    failures;
    int                    num_checks;
    int                    cycles;
    wire logic             sd_line;
    tdm_chain_if l0();
    tdm_chain_if l1();
    assign l1.bit_clk  = l0.bit_clk;
    assign l1.word_sel = l0.chain_trigger_out;
    assign sd_line  = l0.sd_oe ? l0.sd_out : (l1.sd_oe ? l1.sd_out : 1'b0);
    assign l0.sd_in = sd_line;
    assign l1.sd_in = sd_line;
    tdm_master_end i_tdm_master_end (.clk(clk), .sys_rst(sys_rst),
        .link(l0.master), .run(run), .rx_word(rx_word),
        .rx_slot(rx_slot), .rx_valid(rx_valid));
    tdm_mic_end i_tdm_mic_end_0 (.clk(clk), .sys_rst(sys_rst),
        .link(l0.mic), .sample_word(word0), .slot_index(slot0),
        .synced(synced0), .sample_strobe());
    tdm_mic_end i_tdm_mic_end_1 (.clk(clk), .sys_rst(sys_rst),
        .link(l1.mic), .sample_word(word1), .slot_index(slot1),
        .synced(synced1), .sample_strobe());
    tdm_mic_chain_sync_checker i_chk (.clk(clk), .sys_rst(sys_rst),
        .bit_clk(l0.bit_clk), .word_sel(l0.word_sel),
        .chain_trigger_out(l0.chain_trigger_out), .sd_out(l0.sd_out),
        .sd_oe(l0.sd_oe), .sd_in(l0.sd_in));
    always #12.5 clk = ~clk;
    task automatic check(input string name, input logic [23:0] seen,
                         input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic get_word(input logic [3:0] slot, output logic [23:0] w);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!(rx_valid === 1'b1 && rx_slot === slot) && n < 9000);
        if (n >= 9000) failures++;
        w = rx_word;
    endtask
    // Words changed mid-frame stay out until the next frame
    task automatic t_hold(input logic [23:0] n0, input logic [23:0] n1);
        logic [23:0] a;
        logic [23:0] b;
        logic [23:0] o1;
        o1 = word1;
        get_word(4'h0, a);
        word0 = n0;
        word1 = n1;
        get_word(4'h1, b);
        check("held slot 1 word", b, o1);
        get_word(4'h0, a);
        get_word(4'h1, b);
        check("next slot 0 word", a, n0);
        check("next slot 1 word", b, n1);
    endtask
    // Waits for a frame whose slot zero holds the new word
    task automatic t_frames(input logic [23:0] e0, input logic [23:0] e1);
        logic [23:0] a;
        logic [23:0] b;
        for (int f = 0; f < 6; f++) begin
            get_word(4'h0, a);
            get_word(4'h1, b);
            if (a === e0) break;
        end
        check("slot 0 word", a, e0);
        check("slot 1 word", b, e1);
        check("slot index 0", 24'(slot0), 24'h000000);
        check("slot index 1", 24'(slot1), 24'h000001);
        check("synced", 24'({synced0, synced1}), 24'h000003);
    endtask
    task automatic t_restart;
        run = 1'b0;
        repeat (300) @(negedge clk);
        check("synced after stop", 24'({synced0, synced1}), 24'h000000);
        run = 1'b1;
        t_frames(word0, word1);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        run = 1'b0;
        word0 = 24'hA5C3F1;
        word1 = 24'h5A0E96;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        run = 1'b1;
        t_frames(word0, word1);
        word0 = 24'h123456;
        word1 = 24'hFEDCBA;
        t_frames(word0, word1);
        t_hold(24'h0F0F0F, 24'hC33C96);
        t_restart();
        conclude();
    end
endmodule
`default_nettype wire
